/* File: src/abk_top.sv */
// address break comparator: registers, break flag, interrupts
// Functional notes
// RULE1: high data vs upper lane, low vs lower
// RULE2: byte accesses compare only through high byte; code in word data mode also compares the low byte against brk_data_lo
// RULE3: word accesses pick lane by address
// RULE4: data registers have no reset value
// RULE5: break request while flag and enable set
// RULE6: flag set when all conditions match
// RULE7: cpu services break after current instruction
// RULE8: break request ignores cpu interrupt mask
// RULE9: data registers survive non power-on reset
// RULE10: reset restores control, status, address registers
// RULE11: cycle field selects fetch, read, write, both
// RULE12: address field compares 16/12/8/4 bits, 1xx prohibited
// RULE13: data field selects none, low, high, word
// RULE14: flag clears on write 0 after read 1
// RULE15: word access: even upper lane, odd lower
`timescale 1ns/1ps
`default_nettype none
module abk_top
    import abk_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    input  wire abk_bus_s          bus,
    input  wire logic [15:0]       reg_addr,
    input  wire logic [ABK_RW-1:0] reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic [ABK_RW-1:0]      reg_rdata,
    output logic                   break_req,
    output logic                   irq
);

    logic              rst_meta;     // reset release, first stage
    logic              rst_n;        // reset release, second stage
    logic [7:0]        ctrl;         // control register
    logic              flag;         // break flag
    logic              ie;           // break request enable
    logic              flag_armed;   // flag seen as one by software
    logic [ABK_AW-1:0] brk_addr;     // break address word
    logic [7:0]        brk_data_hi;  // break data high byte
    logic [7:0]        brk_data_lo;  // break data low byte
    logic [7:0]        evt_stat;     // sticky event status
    logic [7:0]        evt_en;       // event enable
    abk_cond_s         cond;         // decoded break condition
    logic              hit;          // current bus cycle matches
    logic              match_hit;    // match taken this cycle
    logic              wr_ctrl;      // write strobes per register
    logic              wr_stat;
    logic              wr_addr_h;
    logic              wr_addr_l;
    logic              wr_data_h;
    logic              wr_data_l;
    logic              wr_evt_clr;
    logic              wr_evt_en;
    logic              rd_stat;      // status read strobe
    logic              clr_flag;     // legal software clear of flag
    logic              next_flag;    // flag after this edge
    logic              next_ie;      // enable after this edge
    logic [7:0]        next_evt;     // event status after this edge
    logic [7:0]        next_evt_en;  // event enable after this edge
    logic [7:0]        evt_set;      // event set mask

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // register write and read decode
    assign wr_ctrl    = clk_en && reg_we && (reg_addr == ABK_OFF_CTRL);
    assign wr_stat    = clk_en && reg_we && (reg_addr == ABK_OFF_STAT);
    assign wr_addr_h  = clk_en && reg_we && (reg_addr == ABK_OFF_ADDR_H);
    assign wr_addr_l  = clk_en && reg_we && (reg_addr == ABK_OFF_ADDR_L);
    assign wr_data_h  = clk_en && reg_we && (reg_addr == ABK_OFF_DATA_H);
    assign wr_data_l  = clk_en && reg_we && (reg_addr == ABK_OFF_DATA_L);
    assign wr_evt_clr = clk_en && reg_we && (reg_addr == ABK_OFF_EVT_CLR);
    assign wr_evt_en  = clk_en && reg_we && (reg_addr == ABK_OFF_EVT_EN);
    assign rd_stat    = clk_en && reg_re && (reg_addr == ABK_OFF_STAT);

    // condition fields out of the control register
    assign cond = '{cyc:  abk_cyc_e'(ctrl[ABK_CTRL_CSEL_LSB +: 2]),   // RULE11
                    acmp: abk_acmp_e'(ctrl[ABK_CTRL_ACMP_LSB +: 3]),  // RULE12
                    dcmp: abk_dcmp_e'(ctrl[ABK_CTRL_DCMP_LSB +: 2])}; // RULE13

    // comparator on the watched bus
    abk_match u_match (
        .cond        (cond),
        .bus         (bus),
        .brk_addr    (brk_addr),
        .brk_data_hi (brk_data_hi),
        .brk_data_lo (brk_data_lo),
        .hit         (hit)
    );

    assign match_hit = clk_en && hit; // RULE6

    // control register, cleared by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= ABK_CTRL_RST; // RULE10
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata;
        end
    end

    // break address, reset to all ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brk_addr <= ABK_ADDR_RST; // RULE10
        end else begin
            if (wr_addr_h) begin
                brk_addr[15:8] <= reg_wdata;
            end
            if (wr_addr_l) begin
                brk_addr[7:0] <= reg_wdata;
            end
        end
    end

    // break data, untouched by reset, content unknown until written
    always_ff @(posedge clk) begin
        if (wr_data_h) begin
            brk_data_hi <= reg_wdata; // RULE4 RULE9
        end
        if (wr_data_l) begin
            brk_data_lo <= reg_wdata; // RULE4 RULE9
        end
    end

    // flag clear needs a prior read of one; a match wins over a clear
    assign clr_flag  = wr_stat && !reg_wdata[ABK_STAT_FLAG_BIT] && flag_armed; // RULE14
    assign next_flag = match_hit ? 1'b1 : (clr_flag ? 1'b0 : flag);          // RULE6 RULE14
    assign next_ie   = wr_stat ? reg_wdata[ABK_STAT_IE_BIT] : ie;

    // break flag and enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0; // RULE10
            ie   <= 1'b0;
        end else if (clk_en) begin
            flag <= next_flag;
            ie   <= next_ie;
        end
    end

    // arm tracking: set by a read of one, spent by any status write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_armed <= 1'b0;
        end else if (clk_en) begin
            if (wr_stat || !next_flag) begin
                flag_armed <= 1'b0; // RULE14
            end else if (rd_stat && flag) begin
                flag_armed <= 1'b1; // RULE14
            end
        end
    end

    // dedicated break request line, no mask besides its own enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_req <= 1'b0;
        end else if (clk_en) begin
            break_req <= next_flag && next_ie; // RULE5 RULE8
        end
    end

    // sticky event status; set wins over the write-one clear
    assign evt_set     = {7'h00, match_hit} << ABK_EVT_MATCH_BIT;
    assign next_evt    = (evt_stat & ~(wr_evt_clr ? reg_wdata : 8'h00)) | evt_set;
    assign next_evt_en = wr_evt_en ? reg_wdata : evt_en;

    // event status and enable registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_stat <= ABK_EVT_RST;
            evt_en   <= ABK_EVT_RST;
        end else if (clk_en) begin
            evt_stat <= next_evt;
            evt_en   <= next_evt_en;
        end
    end

    // level interrupt from enabled events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(next_evt & next_evt_en);
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= ABK_RD_UNMAP;
        end else if (clk_en) begin
            reg_rdata <= ABK_RD_UNMAP;
            if (reg_re) begin
                unique case (reg_addr)
                    ABK_OFF_CTRL:     reg_rdata <= ctrl;
                    ABK_OFF_STAT:     reg_rdata <= {flag, ie, ABK_STAT_RSV};
                    ABK_OFF_ADDR_H:   reg_rdata <= brk_addr[15:8];
                    ABK_OFF_ADDR_L:   reg_rdata <= brk_addr[7:0];
                    ABK_OFF_DATA_H:   reg_rdata <= brk_data_hi;
                    ABK_OFF_DATA_L:   reg_rdata <= brk_data_lo;
                    ABK_OFF_EVT_STAT: reg_rdata <= evt_stat;
                    default:          reg_rdata <= ABK_RD_UNMAP; // write-only and unmapped
                endcase
            end
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // software reads the flag as one
    sequence s_read_one;
        clk_en && rd_stat && flag && !wr_stat;
    endsequence

    // software then writes zero, no new match
    sequence s_write_zero;
        clk_en && wr_stat && !reg_wdata[ABK_STAT_FLAG_BIT] && !match_hit;
    endsequence

    // software leaves the status register alone for one cycle
    sequence s_gap;
        !wr_stat;
    endsequence

    AST_BREQ_LEVEL: assert property (break_req == (flag && ie)) // RULE5
        else $error("break request does not follow flag and enable");

    AST_FLAG_SET: assert property (match_hit |=> flag && evt_stat[ABK_EVT_MATCH_BIT]) // RULE6
        else $error("match did not set the flag");

    AST_FLAG_CLEAR: assert property (s_read_one ##1 s_gap ##1 s_write_zero |=> !flag) // RULE14
        else $error("flag not cleared by write of zero after read");

    AST_FLAG_CLEAR_B2B: assert property (s_read_one ##1 s_write_zero |=> !flag) // RULE14
        else $error("flag not cleared by write of zero right after read");

    AST_FLAG_NO_ARM: assert property (clk_en && flag && !flag_armed && wr_stat |=> flag) // RULE14
        else $error("flag cleared without prior read");

    AST_FLAG_HOLD: assert property (clk_en && flag && !wr_stat |=> flag) // RULE14
        else $error("flag dropped without a status write");

    AST_BYTE_HIGH: assert property (hit && !bus.word && cond.cyc != ABK_CYC_FETCH
                                    |-> cond.dcmp != ABK_DCMP_LOW) // RULE2
        else $error("byte access matched through low data byte");

    AST_ODD_WORD: assert property (hit && bus.word && !bus.io8 && bus.addr[0] && cond.cyc != ABK_CYC_FETCH
                                   |-> cond.dcmp != ABK_DCMP_HIGH) // RULE15
        else $error("odd word access compared on upper lane");

    AST_WORD_DATA: assert property (hit && cond.cyc != ABK_CYC_FETCH && cond.dcmp == ABK_DCMP_WORD
                                    |-> bus.data == {brk_data_hi, brk_data_lo}) // RULE1
        else $error("word data match with differing data");

    AST_LOW_LANE: assert property (hit && cond.cyc != ABK_CYC_FETCH && cond.dcmp == ABK_DCMP_LOW
                                   |-> bus.data[7:0] == brk_data_lo && bus.word && bus.addr[0]) // RULE3
        else $error("low byte match outside odd word access");

    AST_DATA_HIGH: assert property (hit && cond.cyc != ABK_CYC_FETCH && cond.dcmp == ABK_DCMP_HIGH
                                    |-> bus.data[15:8] == brk_data_hi && (!bus.word || bus.io8 || !bus.addr[0])) // RULE1
        else $error("high byte match with differing data or lower lane");

    AST_PROHIB: assert property (hit |-> !ctrl[ABK_CTRL_ACMP_LSB + 2]) // RULE12
        else $error("match under prohibited address compare code");

    AST_ADDR_8: assert property (hit && cond.acmp == ABK_ACMP_8 |-> bus.addr[15:8] == brk_addr[15:8]) // RULE12
        else $error("upper address byte mismatch on match");

    AST_ADDR_12: assert property (hit && cond.acmp == ABK_ACMP_12 |-> bus.addr[15:4] == brk_addr[15:4]) // RULE12
        else $error("upper twelve address bits mismatch on match");

    AST_ADDR_4: assert property (hit && cond.acmp == ABK_ACMP_4 |-> bus.addr[15:12] == brk_addr[15:12]) // RULE12
        else $error("upper address nibble mismatch on match");

    AST_FETCH: assert property (hit && cond.cyc == ABK_CYC_FETCH |-> bus.kind == ABK_KIND_FETCH) // RULE11
        else $error("fetch condition matched a data cycle");

    AST_RESET_VAL: assert property ($rose(rst_n) |-> ctrl == ABK_CTRL_RST && brk_addr == ABK_ADDR_RST
                                    && !flag && !ie) // RULE10
        else $error("registers not at reset values after release");

    AST_IRQ_LEVEL: assert property (irq == |(evt_stat & evt_en))
        else $error("interrupt output differs from enabled status");

    AST_STAT_READ: assert property (clk_en && reg_re && reg_addr == ABK_OFF_STAT
                                    |=> reg_rdata == {$past(flag), $past(ie), ABK_STAT_RSV})
        else $error("status read returned wrong value");

endmodule : abk_top
`default_nettype wire

/* File: src/abk_pkg.sv */
// package of constants, types and carriers for the address break comparator
package abk_pkg;

    // widths of the watched buses and of the register port
    localparam int unsigned ABK_AW = 16;
    localparam int unsigned ABK_DW = 16;
    localparam int unsigned ABK_RW = 8;

    // register byte addresses on the register port
    localparam logic [15:0] ABK_OFF_CTRL     = 16'hF096;
    localparam logic [15:0] ABK_OFF_STAT     = 16'hF097;
    localparam logic [15:0] ABK_OFF_ADDR_H   = 16'hF098;
    localparam logic [15:0] ABK_OFF_ADDR_L   = 16'hF099;
    localparam logic [15:0] ABK_OFF_DATA_H   = 16'hF09A;
    localparam logic [15:0] ABK_OFF_DATA_L   = 16'hF09B;
    localparam logic [15:0] ABK_OFF_EVT_STAT = 16'hF09C;
    localparam logic [15:0] ABK_OFF_EVT_CLR  = 16'hF09D;
    localparam logic [15:0] ABK_OFF_EVT_EN   = 16'hF09E;

    // field positions in the control register
    localparam int unsigned ABK_CTRL_RTE_BIT  = 7;
    localparam int unsigned ABK_CTRL_CSEL_LSB = 5;
    localparam int unsigned ABK_CTRL_ACMP_LSB = 2;
    localparam int unsigned ABK_CTRL_DCMP_LSB = 0;

    // field positions in the status register and the event registers
    localparam int unsigned ABK_STAT_FLAG_BIT = 7;
    localparam int unsigned ABK_STAT_IE_BIT   = 6;
    localparam int unsigned ABK_EVT_MATCH_BIT = 0;

    // reset values and fixed read values
    localparam logic [7:0]  ABK_CTRL_RST  = 8'h00;
    localparam logic [5:0]  ABK_STAT_RSV  = 6'h3F;
    localparam logic [15:0] ABK_ADDR_RST  = 16'hFFFF;
    localparam logic [7:0]  ABK_EVT_RST   = 8'h00;
    localparam logic [7:0]  ABK_RD_UNMAP  = 8'h00;

    // cycle condition select codes
    typedef enum logic [1:0] {
        ABK_CYC_FETCH = 2'h0,
        ABK_CYC_READ  = 2'h1,
        ABK_CYC_WRITE = 2'h2,
        ABK_CYC_RW    = 2'h3
    } abk_cyc_e;

    // address compare select codes, top bit set is prohibited
    typedef enum logic [2:0] {
        ABK_ACMP_16 = 3'h0,
        ABK_ACMP_12 = 3'h1,
        ABK_ACMP_8  = 3'h2,
        ABK_ACMP_4  = 3'h3
    } abk_acmp_e;

    // data compare select codes
    typedef enum logic [1:0] {
        ABK_DCMP_NONE = 2'h0,
        ABK_DCMP_LOW  = 2'h1,
        ABK_DCMP_HIGH = 2'h2,
        ABK_DCMP_WORD = 2'h3
    } abk_dcmp_e;

    // kind of cycle seen on the cpu bus
    typedef enum logic [1:0] {
        ABK_KIND_FETCH = 2'h0,
        ABK_KIND_READ  = 2'h1,
        ABK_KIND_WRITE = 2'h2
    } abk_kind_e;

    // break condition as held in the control register
    typedef struct packed {
        abk_cyc_e  cyc;
        abk_acmp_e acmp;
        abk_dcmp_e dcmp;
    } abk_cond_s;

    // one observed cpu bus cycle
    typedef struct packed {
        logic              valid;
        abk_kind_e         kind;
        logic              word;
        logic              io8;
        logic [ABK_AW-1:0] addr;
        logic [ABK_DW-1:0] data;
    } abk_bus_s;

endpackage : abk_pkg

/* File: src/abk_match.sv */
// combinational match of one cpu bus cycle against the break condition
`timescale 1ns/1ps
`default_nettype none
module abk_match
    import abk_pkg::*;
(
    input  wire abk_cond_s         cond,
    input  wire abk_bus_s          bus,
    input  wire logic [ABK_AW-1:0] brk_addr,
    input  wire logic [7:0]        brk_data_hi,
    input  wire logic [7:0]        brk_data_lo,
    output logic                   hit
);

    logic [ABK_AW-1:0] amask;     // address bits that take part
    logic              acmp_ok;   // legal address compare code
    logic              cyc_ok;    // cycle kind fits condition
    logic              lane_up;   // compared byte on upper lane
    logic              data_ok;   // data condition met

    // address mask from compare select
    always_comb begin
        amask   = 16'hFFFF;
        acmp_ok = 1'b1;
        unique case (cond.acmp)
            ABK_ACMP_16: amask = 16'hFFFF;
            ABK_ACMP_12: amask = 16'hFFF0;
            ABK_ACMP_8:  amask = 16'hFF00;
            ABK_ACMP_4:  amask = 16'hF000;
            default:     acmp_ok = 1'b0; // RULE12
        endcase
    end

    // cycle kind check
    always_comb begin
        cyc_ok = 1'b0;
        unique case (cond.cyc) // RULE11
            ABK_CYC_FETCH: cyc_ok = (bus.kind == ABK_KIND_FETCH);
            ABK_CYC_READ:  cyc_ok = (bus.kind == ABK_KIND_READ);
            ABK_CYC_WRITE: cyc_ok = (bus.kind == ABK_KIND_WRITE);
            ABK_CYC_RW:    cyc_ok = (bus.kind == ABK_KIND_READ) || (bus.kind == ABK_KIND_WRITE);
        endcase
    end

    // byte accesses and 8-bit io use upper lane; word odd uses lower
    assign lane_up = !bus.word || bus.io8 || !bus.addr[0]; // RULE2 RULE3 RULE15

    // data check, skipped for instruction fetch
    always_comb begin
        data_ok = 1'b1;
        if (cond.cyc != ABK_CYC_FETCH) begin
            unique case (cond.dcmp)
                ABK_DCMP_NONE: data_ok = 1'b1;
                ABK_DCMP_LOW:  data_ok = !lane_up && (bus.data[7:0] == brk_data_lo); // RULE1
                ABK_DCMP_HIGH: data_ok = lane_up && (bus.data[15:8] == brk_data_hi); // RULE1
                ABK_DCMP_WORD: data_ok = (bus.data == {brk_data_hi, brk_data_lo});   // RULE1
            endcase
        end
    end

    // all conditions together
    assign hit = bus.valid && acmp_ok && cyc_ok && data_ok
                 && ((bus.addr & amask) == (brk_addr & amask)); // RULE6

endmodule : abk_match
`default_nettype wire

/* File: testbench/abk_cpu_model.sv */
// cpu side model: drives watched bus cycles and accepts the break line
`timescale 1ns/1ps
`default_nettype none
module abk_cpu_model
    import abk_pkg::*;
#(
    parameter int unsigned INSTR_LEN = 3 // states in one instruction
)(
    input  wire logic     clk,
    input  wire logic     rstn,
    input  wire logic     break_req,
    input  wire logic     i_mask,
    output var  abk_bus_s bus,
    output logic          taken
);
    logic [3:0] step; // state count inside the current instruction

    // bus idle from time zero, no stale cycle shown
    initial begin
        bus = '0;
        bus.addr = 16'h5555;
        bus.data = 16'hAAAA;
    end

    // one bus cycle; on release addr and data show their inverse
    task automatic cycle(input abk_kind_e k, input logic [1:0] wi, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{valid: 1'b1, kind: k, word: wi[1], io8: wi[0], addr: a, data: d};
        @(posedge clk);
        bus <= '{valid: 1'b0, kind: k, word: wi[1], io8: wi[0], addr: ~a, data: ~d};
        #1;
    endtask : cycle

    // break taken only at an instruction end; i_mask has no say here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step  <= 4'h0;
            taken <= 1'b0;
        end else begin
            step  <= (step == 4'(INSTR_LEN - 1)) ? 4'h0 : step + 4'h1;
            taken <= break_req && (step == 4'(INSTR_LEN - 1));
        end
    end
endmodule : abk_cpu_model
`default_nettype wire

/* File: testbench/abk_top_test.sv */
// self-checking bench for the address break comparator
`timescale 1ns/1ps
`default_nettype none
module abk_top_test;
    import abk_pkg::*;

    localparam abk_kind_e RD = ABK_KIND_READ;  // data read cycle
    localparam abk_kind_e WR = ABK_KIND_WRITE; // data write cycle
    localparam abk_kind_e FE = ABK_KIND_FETCH; // instruction fetch

    logic        clk;          // 100 MHz clock
    logic        rstn;         // async reset, active low
    logic        clk_en;       // state update enable
    logic [15:0] reg_addr;     // register address
    logic [7:0]  reg_wdata;    // register write data
    logic        reg_we;       // write strobe
    logic        reg_re;       // read strobe
    logic        i_mask;       // cpu interrupt mask
    wire  [7:0]  reg_rdata;    // read data
    wire         break_req;    // break line to the cpu
    wire         irq;          // event interrupt
    wire         taken;        // break accepted by cpu
    abk_bus_s    bus;          // watched cpu cycle
    int          mismatches;   // failed comparisons
    int          total_checks; // comparisons made

    abk_top u_abk_top (
        .clk(clk), .rstn(rstn), .clk_en(clk_en), .bus(bus), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .break_req(break_req), .irq(irq)
    );

    abk_cpu_model u_abk_cpu_model (
        .clk(clk), .rstn(rstn), .break_req(break_req), .i_mask(i_mask), .bus(bus), .taken(taken)
    );

    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle register write
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask : wr

    // one-cycle register read, data checked in the following cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // let one edge land
    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle

    // program condition, run one cycle, check flag and break line, clear
    task automatic try(input logic [7:0] c, input abk_kind_e k, input logic [1:0] wi,
                       input logic [15:0] a, input logic [15:0] d, input logic hit);
        wr(ABK_OFF_CTRL, c);
        u_abk_cpu_model.cycle(k, wi, a, d);
        chk(break_req, hit);
        rd(ABK_OFF_STAT, {hit, 7'h7F});
        if (hit) begin
            wr(ABK_OFF_STAT, 8'h40);
            settle();
            chk(break_req, 1'b0);
        end
    endtask : try

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // hang guard
    initial begin
        #200us;
        mismatches++;
        stop_test();
    end

    // main sequence
    initial begin
        int n;
        rstn = 1'b0;
        clk_en = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
        i_mask = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        // reset values, unmapped and write-only places read zero
        rd(ABK_OFF_CTRL, 8'h00);
        rd(ABK_OFF_STAT, 8'h3F);
        rd(ABK_OFF_ADDR_H, 8'hFF);
        rd(ABK_OFF_ADDR_L, 8'hFF);
        rd(ABK_OFF_EVT_STAT, 8'h00);
        rd(ABK_OFF_EVT_EN, 8'h00);
        rd(ABK_OFF_EVT_CLR, 8'h00);
        rd(16'hF095, 8'h00);
        chk({break_req, irq}, 2'h0);
        // data registers survive a mid-run reset, others return to reset
        wr(ABK_OFF_DATA_H, 8'hA5);
        wr(ABK_OFF_DATA_L, 8'h5A);
        wr(ABK_OFF_ADDR_H, 8'h12);
        wr(ABK_OFF_CTRL, 8'h63);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rd(ABK_OFF_DATA_H, 8'hA5);
        rd(ABK_OFF_DATA_L, 8'h5A);
        rd(ABK_OFF_ADDR_H, 8'hFF);
        rd(ABK_OFF_CTRL, 8'h00);
        // writes with clk_en low are dropped
        @(posedge clk);
        clk_en <= 1'b0;
        wr(ABK_OFF_CTRL, 8'h1C);
        clk_en <= 1'b1;
        rd(ABK_OFF_CTRL, 8'h00);
        wr(ABK_OFF_ADDR_H, 8'h12);
        wr(ABK_OFF_ADDR_L, 8'h34);
        wr(ABK_OFF_STAT, 8'h40);
        rd(ABK_OFF_ADDR_L, 8'h34);
        // byte lanes, data compare modes
        try(8'h66, RD, 2'h0, 16'h1235, 16'hA500, 1'b1);
        try(8'h66, RD, 2'h0, 16'h1234, 16'h00A5, 1'b0);
        try(8'h65, WR, 2'h0, 16'h1234, 16'h005A, 1'b0);
        try(8'h65, WR, 2'h2, 16'h1235, 16'h005A, 1'b1);
        try(8'h66, RD, 2'h2, 16'h1235, 16'hA500, 1'b0);
        try(8'h66, RD, 2'h2, 16'h1234, 16'hA500, 1'b1);
        try(8'h65, RD, 2'h2, 16'h1234, 16'h005A, 1'b0);
        try(8'h66, RD, 2'h3, 16'h1235, 16'hA500, 1'b1);
        try(8'h63, RD, 2'h2, 16'h1234, 16'hA55A, 1'b1);
        try(8'h63, RD, 2'h2, 16'h1234, 16'hA55B, 1'b0);
        try(8'h63, RD, 2'h2, 16'h1234, 16'hA45A, 1'b0);
        // address compare widths
        try(8'h60, RD, 2'h0, 16'h1235, 16'h0000, 1'b0);
        try(8'h64, RD, 2'h0, 16'h123F, 16'h0000, 1'b1);
        try(8'h64, RD, 2'h0, 16'h124F, 16'h0000, 1'b0);
        try(8'h68, RD, 2'h0, 16'h12FF, 16'h0000, 1'b1);
        try(8'h68, RD, 2'h0, 16'h1334, 16'h0000, 1'b0);
        try(8'h6C, RD, 2'h0, 16'h1FFF, 16'h0000, 1'b1);
        try(8'h6C, RD, 2'h0, 16'h2234, 16'h0000, 1'b0);
        try(8'h70, RD, 2'h0, 16'h1234, 16'h0000, 1'b0);
        // cycle conditions
        try(8'h03, FE, 2'h2, 16'h1234, 16'h0000, 1'b1);
        try(8'h00, RD, 2'h0, 16'h1234, 16'h0000, 1'b0);
        try(8'h20, WR, 2'h0, 16'h1234, 16'h0000, 1'b0);
        try(8'h20, RD, 2'h0, 16'h1234, 16'h0000, 1'b1);
        try(8'h40, WR, 2'h0, 16'h1234, 16'h0000, 1'b1);
        try(8'h40, RD, 2'h0, 16'h1234, 16'h0000, 1'b0);
        try(8'h60, WR, 2'h0, 16'h1234, 16'h0000, 1'b1);
        // flag clear protocol, enable gating, mask-free acceptance
        u_abk_cpu_model.cycle(WR, 2'h0, 16'h1234, 16'h0000);
        wr(ABK_OFF_STAT, 8'h00);
        settle();
        chk(break_req, 1'b0);
        wr(ABK_OFF_STAT, 8'h40);
        settle();
        chk(break_req, 1'b1);
        i_mask <= 1'b1;
        for (n = 0; n < 8 && taken !== 1'b1; n++) begin
            settle();
        end
        chk(taken, 1'b1);
        rd(ABK_OFF_STAT, 8'hFF);
        wr(ABK_OFF_STAT, 8'hC0);
        rd(ABK_OFF_STAT, 8'hFF);
        wr(ABK_OFF_STAT, 8'h40);
        rd(ABK_OFF_STAT, 8'h7F);
        // event status, enable and clear
        wr(ABK_OFF_EVT_EN, 8'h01);
        settle();
        chk(irq, 1'b1);
        wr(ABK_OFF_EVT_EN, 8'h00);
        settle();
        chk(irq, 1'b0);
        wr(ABK_OFF_EVT_CLR, 8'h01);
        rd(ABK_OFF_EVT_STAT, 8'h00);
        wr(ABK_OFF_EVT_EN, 8'h01);
        u_abk_cpu_model.cycle(WR, 2'h0, 16'h1234, 16'h0000);
        chk(irq, 1'b1);
        wr(ABK_OFF_EVT_CLR, 8'h01);
        settle();
        chk(irq, 1'b0);
        stop_test();
    end
endmodule : abk_top_test
`default_nettype wire
